// ### test/sepr_eeprom_assertions.sv
// port checker for the spi eeprom sequencer
`timescale 1ns/1ns
module sepr_chk #(
  parameter int AW       = 13,
  parameter int PROG_CYC = sepr_pkg::SEPR_PROG_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_cs_n,
  input wire logic i_sck,
  input wire logic i_si,
  input wire logic i_wp_n,
  input wire logic o_so,
  input wire logic o_so_oe_n,
  input wire logic o_busy
);
  int cnt_q;
  int cnt_d;
  always_comb cnt_d = o_busy ? cnt_q + 1 : 0;
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst)
      cnt_q <= 0;
    else
      cnt_q <= cnt_d;
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  AST_OE_IDLE: assert property (i_cs_n [*5] |-> o_so_oe_n)
    else $error("output driven while deselected");
  AST_OE_LATE: assert property ($fell(o_so_oe_n) |-> !i_cs_n && !$past(i_cs_n, 8))
    else $error("output enabled too early");
  // so only moves shortly after a clock fall, never late in the high phase
  AST_SO_HOLD: assert property (i_sck [*3] |-> $stable(o_so))
    else $error("output moved during clock high");
  AST_BUSY_CS: assert property ($rose(o_busy) |-> i_cs_n && $past(i_cs_n))
    else $error("busy started while selected");
  AST_BUSY_SEL: assert property (!i_cs_n |-> !$rose(o_busy))
    else $error("busy rose inside a frame");
  AST_BUSY_LEN: assert property ($fell(o_busy) |-> cnt_q == PROG_CYC)
    else $error("busy length wrong");
  AST_BUSY_MAX: assert property (o_busy |-> cnt_q < PROG_CYC)
    else $error("busy too long");
  AST_NO_REBUSY: assert property ($fell(o_busy) |-> !o_busy [*8])
    else $error("busy restarted at once");
  cover property ($rose(o_busy));
  cover property ($fell(o_busy));
  cover property ($fell(o_so_oe_n));
endmodule
bind sepr_eeprom sepr_chk #(.AW(AW), .PROG_CYC(PROG_CYC)) u_chk (
  .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_cs_n(i_cs_n), .i_sck(i_sck),
  .i_si(i_si), .i_wp_n(i_wp_n), .o_so(o_so), .o_so_oe_n(o_so_oe_n), .o_busy(o_busy));

// ### test/sepr_spi_master.sv
// spi mode 0 master model, clock free of the system clock
`timescale 1ns/1ns
module sepr_spi_master (
  output logic      o_cs_n,
  output logic      o_sck,
  output logic      o_si,
  input  wire logic i_so
);
  initial begin
    o_cs_n = 1'b1;
    o_sck  = 1'b0;
    o_si   = 1'b0;
  end
  task automatic start();
    #37 o_cs_n = 1'b0;
    #40;
  endtask
  // msb first; so read late in the high phase where it is settled
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      o_si = tx[i];
      #40 o_sck = 1'b1;
      #40 rx[i] = i_so;
      o_sck = 1'b0;
    end
  endtask
  // select rises in the low phase right after the last bit
  task automatic stop();
    #20 o_cs_n = 1'b1;
    o_si = ~o_si;
    #60;
  endtask
endmodule

// ### test/testbench.sv
// self-checking bench for the spi eeprom sequencer
`timescale 1ns/1ns
module testbench;
  logic       i_sys_clk = 1'b0;
  logic       i_rst     = 1'b1;
  logic       i_wp_n    = 1'b1;
  logic       cs_n, sck, si, so, so_oe_n, busy;
  int         error_cnt = 0;
  int         n_tests   = 0;
  logic [7:0] r[$];
  logic [7:0] q[$];
  // released line shows the opposite level, not a stale copy
  wire        so_w = so_oe_n ? ~so : so;
  always #5 i_sys_clk = ~i_sys_clk;
  sepr_eeprom #(.AW(13), .PROG_CYC(300)) u_dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
    .i_cs_n(cs_n), .i_sck(sck), .i_si(si), .i_wp_n(i_wp_n), .o_so(so),
    .o_so_oe_n(so_oe_n), .o_busy(busy));
  sepr_spi_master u_mst (.o_cs_n(cs_n), .o_sck(sck), .o_si(si), .i_so(so_w));
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic op(input logic [7:0] b[$]);
    logic [7:0] x;
    r = {};
    u_mst.start();
    foreach (b[i]) begin
      u_mst.xfer(b[i], x);
      r.push_back(x);
    end
    u_mst.stop();
  endtask
  task automatic st(input logic [7:0] exp);
    op({8'h05, 8'h00});
    chk("status", exp, r[1]);
  endtask
  task automatic wait_rdy();
    for (int k = 0; k < 20; k++) begin
      op({8'h05, 8'h00});
      if (r[1][0] === 1'b0)
        return;
    end
    error_cnt++;
    summarize();
  endtask
  task automatic wr(input logic [7:0] b[$]);
    op({8'h06});
    op(b);
    wait_rdy();
  endtask
  initial begin
    repeat (12) @(posedge i_sys_clk);
    #2 i_rst = 1'b0;
    #100;
    st(8'h00);
    op({8'h02, 8'h00, 8'h10, 8'h5a});
    st(8'h00);
    op({8'h0e});
    st(8'h02);
    op({8'h0c});
    st(8'h00);
    // 33 bytes from offset 1e: wraps, upper address bits ignored
    op({8'h06});
    q = {8'h02, 8'hff, 8'hfe};
    for (int i = 0; i < 33; i++) q.push_back(8'h40 + 8'(i));
    op(q);
    chk("busy_on", 8'h01, {7'h0, busy});
    // status write while busy must neither land nor cancel the page
    op({8'h01, 8'h8c});
    st(8'hff);
    wait_rdy();
    chk("busy_off", 8'h00, {7'h0, busy});
    st(8'h00);
    op({8'h06});
    op({8'h02, 8'h00, 8'h00, 8'h77});
    wait_rdy();
    op({8'h0b, 8'h1f, 8'hfd, 8'h06, 8'h06, 8'h06, 8'h06});
    chk("rd_1ffd", 8'h5f, r[3]);
    chk("rd_1ffe", 8'h60, r[4]);
    chk("rd_1fff", 8'h41, r[5]);
    chk("rd_0000", 8'h77, r[6]);
    st(8'h00);
    op({8'h06});
    op({8'h01, 8'h8c});
    wait_rdy();
    st(8'h8c);
    op({8'h06});
    op({8'h02, 8'h00, 8'h00, 8'h11});
    wait_rdy();
    op({8'h03, 8'h00, 8'h00, 8'h00});
    chk("guarded", 8'h77, r[3]);
    @(posedge i_sys_clk);
    #2 i_wp_n = 1'b0;
    op({8'h06});
    op({8'h01, 8'h00});
    op({8'h05, 8'h00});
    chk("pin_lock", 8'h8c, r[1] & 8'hfd);
    @(posedge i_sys_clk);
    #2 i_wp_n = 1'b1;
    op({8'h06});
    op({8'h01, 8'h00});
    wait_rdy();
    st(8'h00);
    // quarter then half guard; bytes below the guarded range stay writable
    wr({8'h01, 8'h04});
    wr({8'h02, 8'h1f, 8'hfd, 8'h00});
    wr({8'h02, 8'h17, 8'hff, 8'h33});
    op({8'h03, 8'h1f, 8'hfd, 8'h00, 8'h00});
    chk("quarter_top", 8'h5f, r[3]);
    chk("quarter_top_next", 8'h60, r[4]);
    op({8'h03, 8'h17, 8'hff, 8'h00});
    chk("quarter_below", 8'h33, r[3]);
    wr({8'h01, 8'h08});
    wr({8'h02, 8'h17, 8'hff, 8'h44});
    wr({8'h02, 8'h0f, 8'hff, 8'h55});
    op({8'h03, 8'h17, 8'hff, 8'h00});
    chk("half_top", 8'h33, r[3]);
    op({8'h03, 8'h0f, 8'hff, 8'h00});
    chk("half_below", 8'h55, r[3]);
    st(8'h08);
    summarize();
  end
endmodule

// ### verilog/sepr_eeprom.sv
// spi mode 0 eeprom command sequencer with page write and block protection
// Overview of operation
// - read opcode, 16-bit address, data shifts out
// - serial input ignored after read address
// - address increments each byte while selected
// - read address wraps past top to zero
// - never program block-protected addresses
// - while programming only status read accepted
// - programming begins when select rises
// - busy bit one during programming only
// - page write increments low five address bits
// - over 32 bytes wraps and overwrites page
// - programming completion clears write latch
// - write discarded when latch is clear
// - protect pin blocks status writes when enabled
// - decode six opcodes with don't-care bit
// - status layout; all ones while programming
// - level bits select none, quarter, half, all
`timescale 1ns/1ns
module sepr_eeprom #(
  parameter int AW       = 13,
  parameter int PROG_CYC = sepr_pkg::SEPR_PROG_CYC
) (
  input  wire logic i_sys_clk,
  input  wire logic i_rst,
  input  wire logic i_cs_n,
  input  wire logic i_sck,
  input  wire logic i_si,
  input  wire logic i_wp_n,
  output logic      o_so,
  output logic      o_so_oe_n,
  output logic      o_busy
);
  localparam int PB  = sepr_pkg::SEPR_PAGE_BITS;
  localparam int NPG = 1 << PB;

  logic [2:0] cs_s_q, sck_s_q, si_s_q, wp_s_q;
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      cs_s_q  <= 3'h7;
      sck_s_q <= 3'h0;
      si_s_q  <= 3'h0;
      wp_s_q  <= 3'h7;
    end else begin
      cs_s_q  <= {cs_s_q[1:0], i_cs_n};
      sck_s_q <= {sck_s_q[1:0], i_sck};
      si_s_q  <= {si_s_q[1:0], i_si};
      wp_s_q  <= {wp_s_q[1:0], i_wp_n};
    end
  end
  wire cs_n  = cs_s_q[1];
  wire cs_up = cs_s_q[1] & ~cs_s_q[2];
  wire sck_r = sck_s_q[1] & ~sck_s_q[2];
  wire sck_f = ~sck_s_q[1] & sck_s_q[2];
  wire si    = si_s_q[1];
  wire wp_n  = wp_s_q[1];

  function automatic logic opc_is(input logic [7:0] v, input logic [7:0] c);
    opc_is = ((v & sepr_pkg::SEPR_OPC_MASK) == c);
  endfunction

  // top of array guarded per level, compared on the aw-bit address
  function automatic logic guarded(input logic [AW-1:0] a, input logic [1:0] lvl);
    case (lvl)
      2'b01:   guarded = &a[AW-1 -: 2];
      2'b10:   guarded = a[AW-1];
      2'b11:   guarded = 1'b1;
      default: guarded = 1'b0;
    endcase
  endfunction

  logic [7:0] mem [0:(1<<AW)-1];
  logic [7:0] page_q [0:NPG-1];
  logic [7:0] page_d [0:NPG-1];
  logic [NPG-1:0] pvld_q, pvld_d;

  sepr_pkg::sepr_state_t st_q, st_d;
  logic [7:0]  sh_q, sh_d, obuf_q, obuf_d, op_q, op_d;
  logic [3:0]  bit_q, bit_d;
  logic [4:0]  acnt_q, acnt_d;
  logic [AW-1:0] addr_q, addr_d;
  logic        wel_q, wel_d, pinen_q, pinen_d;
  logic [1:0]  lvl_q, lvl_d;
  logic [7:0]  sr_new_q, sr_new_d;
  logic        arm_q, arm_d, srw_q, srw_d, prog_q, prog_d;
  logic [31:0] tmr_q, tmr_d;
  logic        so_q, so_d, oen_q, oen_d;
  logic [7:0]  nb;
  logic [7:0]  status;
  logic        we_mem;

  always_comb begin
    status = {pinen_q, 3'h0, lvl_q, wel_q, 1'b0};
    if (prog_q) status = sepr_pkg::SEPR_BUSY_STATUS;
  end

  always_comb begin
    st_d = st_q; sh_d = sh_q; obuf_d = obuf_q; op_d = op_q; bit_d = bit_q;
    acnt_d = acnt_q; addr_d = addr_q; wel_d = wel_q; lvl_d = lvl_q;
    pinen_d = pinen_q; sr_new_d = sr_new_q; arm_d = arm_q; srw_d = srw_q;
    prog_d = prog_q; tmr_d = tmr_q; so_d = so_q; oen_d = oen_q;
    pvld_d = pvld_q; we_mem = 1'b0;
    for (int i = 0; i < NPG; i++) page_d[i] = page_q[i];
    nb = {sh_q[6:0], si};
    if (prog_q) begin
      if (tmr_q == 32'(PROG_CYC - 1)) begin
        prog_d = 1'b0;
        wel_d  = 1'b0;
        pvld_d = '0;
        we_mem = ~srw_q;
        if (srw_q) begin
          pinen_d = sr_new_q[sepr_pkg::SEPR_PIN_BIT];
          lvl_d   = sr_new_q[sepr_pkg::SEPR_LVL_HI:sepr_pkg::SEPR_LVL_LO];
        end
      end else tmr_d = tmr_q + 32'h1;
    end
    if (cs_n) begin
      st_d = sepr_pkg::SEPR_OPC; bit_d = 4'h0; oen_d = 1'b1;
      if (cs_up && arm_q && bit_q == 4'h0 && !prog_q) begin
        prog_d = 1'b1; tmr_d = 32'h0;
      end
      arm_d = 1'b0;
    end else begin
      if (sck_f && !oen_q) begin
        so_d = obuf_q[7]; obuf_d = {obuf_q[6:0], 1'b0};
      end
      if (sck_r) begin
        sh_d  = nb;
        bit_d = (bit_q == 4'h7) ? 4'h0 : bit_q + 4'h1;
        // shift the address first so the byte-end decode sees all bits
        if (st_q == sepr_pkg::SEPR_ADDR) addr_d = {addr_q[AW-2:0], si};
        if (bit_q == 4'h7) begin
          case (st_q)
            sepr_pkg::SEPR_OPC: begin
              op_d = nb; st_d = sepr_pkg::SEPR_IGNORE;
              if (opc_is(nb, sepr_pkg::SEPR_OPC_SRD)) begin
                st_d = sepr_pkg::SEPR_SOUT; obuf_d = status; oen_d = 1'b0;
              end else if (!prog_q) begin
                if (opc_is(nb, sepr_pkg::SEPR_OPC_SET)) wel_d = 1'b1;
                else if (opc_is(nb, sepr_pkg::SEPR_OPC_CLR)) wel_d = 1'b0;
                else if (opc_is(nb, sepr_pkg::SEPR_OPC_READ)) begin
                  st_d = sepr_pkg::SEPR_ADDR; acnt_d = 5'h0;
                end else if (opc_is(nb, sepr_pkg::SEPR_OPC_WRITE) && wel_q) begin
                  st_d = sepr_pkg::SEPR_ADDR; acnt_d = 5'h0;
                end else if (opc_is(nb, sepr_pkg::SEPR_OPC_SWR) && wel_q
                             && !(pinen_q && !wp_n))
                  st_d = sepr_pkg::SEPR_STREG;
              end
            end
            sepr_pkg::SEPR_ADDR: begin
              acnt_d = acnt_q + 5'h1;
              if (acnt_q == 5'h1) begin
                if (opc_is(op_q, sepr_pkg::SEPR_OPC_READ)) begin
                  st_d = sepr_pkg::SEPR_RDATA;
                  obuf_d = mem[addr_d]; oen_d = 1'b0;
                  addr_d = addr_d + AW'(1);
                end else begin
                  st_d = sepr_pkg::SEPR_WDATA; pvld_d = '0;
                end
              end
            end
            sepr_pkg::SEPR_RDATA: begin
              obuf_d = mem[addr_q];
              addr_d = addr_q + AW'(1);
            end
            sepr_pkg::SEPR_WDATA: begin
              page_d[addr_q[PB-1:0]] = nb;
              pvld_d[addr_q[PB-1:0]] = 1'b1;
              addr_d = {addr_q[AW-1:PB], addr_q[PB-1:0] + 5'h1};
              arm_d = 1'b1;
            end
            sepr_pkg::SEPR_STREG: begin
              sr_new_d = nb; arm_d = 1'b1; srw_d = 1'b1;
            end
            sepr_pkg::SEPR_SOUT: obuf_d = status;
            default: ;
          endcase
        end
        // a status poll during programming must not drop a pending status write
        if (st_q == sepr_pkg::SEPR_OPC && bit_q == 4'h0 && !prog_q) srw_d = 1'b0;
      end
      if (st_q == sepr_pkg::SEPR_STREG && pinen_q && !wp_n) begin
        st_d = sepr_pkg::SEPR_IGNORE; arm_d = 1'b0;
      end
    end
  end

  // programming writes only unguarded page bytes back to the array
  always_ff @(posedge i_sys_clk) begin
    if (we_mem) begin
      for (int i = 0; i < NPG; i++) begin
        if (pvld_q[i] && !guarded({addr_q[AW-1:PB], PB'(i)}, lvl_q))
          mem[{addr_q[AW-1:PB], PB'(i)}] <= page_q[i];
      end
    end
    for (int i = 0; i < NPG; i++) page_q[i] <= page_d[i];
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      st_q <= sepr_pkg::SEPR_OPC; sh_q <= 8'h0; obuf_q <= 8'h0; op_q <= 8'h0;
      bit_q <= 4'h0; acnt_q <= 5'h0; addr_q <= '0; wel_q <= 1'b0;
      lvl_q <= 2'h0; pinen_q <= 1'b0; sr_new_q <= sepr_pkg::SEPR_STATUS_RST;
      arm_q <= 1'b0; srw_q <= 1'b0; prog_q <= 1'b0; tmr_q <= 32'h0;
      so_q <= 1'b0; oen_q <= 1'b1; pvld_q <= '0;
    end else begin
      st_q <= st_d; sh_q <= sh_d; obuf_q <= obuf_d; op_q <= op_d;
      bit_q <= bit_d; acnt_q <= acnt_d; addr_q <= addr_d; wel_q <= wel_d;
      lvl_q <= lvl_d; pinen_q <= pinen_d; sr_new_q <= sr_new_d;
      arm_q <= arm_d; srw_q <= srw_d; prog_q <= prog_d; tmr_q <= tmr_d;
      so_q <= so_d; oen_q <= oen_d; pvld_q <= pvld_d;
    end
  end

  assign o_so      = so_q;
  assign o_so_oe_n = oen_q;
  assign o_busy    = prog_q;
endmodule

// ### verilog/sepr_pkg.sv
// constants for the spi eeprom command sequencer
package sepr_pkg;
  localparam logic [7:0] SEPR_OPC_MASK  = 8'hf7;
  localparam logic [7:0] SEPR_OPC_SET   = 8'h06;
  localparam logic [7:0] SEPR_OPC_CLR   = 8'h04;
  localparam logic [7:0] SEPR_OPC_SRD   = 8'h05;
  localparam logic [7:0] SEPR_OPC_SWR   = 8'h01;
  localparam logic [7:0] SEPR_OPC_READ  = 8'h03;
  localparam logic [7:0] SEPR_OPC_WRITE = 8'h02;
  localparam int SEPR_BUSY_BIT  = 0;
  localparam int SEPR_LATCH_BIT = 1;
  localparam int SEPR_LVL_LO    = 2;
  localparam int SEPR_LVL_HI    = 3;
  localparam int SEPR_PIN_BIT   = 7;
  localparam int SEPR_PAGE_BITS = 5;
  localparam int SEPR_ADDR_BITS = 16;
  localparam logic [7:0] SEPR_STATUS_RST = 8'h00;
  localparam logic [7:0] SEPR_BUSY_STATUS = 8'hff;
  localparam int SEPR_PROG_TIME_NS = 5000;
  localparam int SEPR_CLK_NS = 10;
  localparam int SEPR_PROG_CYC = (SEPR_PROG_TIME_NS + SEPR_CLK_NS - 1) / SEPR_CLK_NS;
  typedef enum logic [2:0] {
    SEPR_OPC, SEPR_ADDR, SEPR_RDATA, SEPR_WDATA, SEPR_STREG, SEPR_SOUT, SEPR_IGNORE
  } sepr_state_t;
endpackage
